// file: verilog/word_aligner_regs.svh
// register offsets, field positions and reset values of the word aligner
`ifndef WORD_ALIGNER_REGS_SVH
`define WORD_ALIGNER_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define WA_CTRL_OFS 12'h000
`define WA_PAT_LO_OFS 12'h004
`define WA_PAT_HI_OFS 12'h008
`define WA_SYNC_CFG_OFS 12'h00C
`define WA_STATUS_OFS 12'h010
`define WA_INT_STAT_OFS 12'h014
`define WA_INT_MASK_OFS 12'h018

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define WA_CTRL_MODE_LSB 0
`define WA_CTRL_PLEN_LSB 2
`define WA_CTRL_PMAW_LSB 5
`define WA_CTRL_ENC_BIT 7
`define WA_CTRL_FAST_BIT 8
`define WA_CTRL_CPRI_BIT 9
`define WA_CTRL_TXSLIP_BIT 10
`define WA_CTRL_TXSEL_BIT 11
`define WA_CTRL_REALIGN_BIT 12
`define WA_CTRL_A1A2_BIT 13
`define WA_CTRL_RXBND_BIT 14
`define WA_CTRL_RXSLIP_BIT 15
`define WA_CTRL_RST 32'h0000_0078

// ----------------------------------------------------------------------
// sync configuration fields and reset values
// ----------------------------------------------------------------------
`define WA_CFG_SYNC_LSB 0
`define WA_CFG_ERR_LSB 8
`define WA_CFG_GOOD_LSB 16
`define WA_SYNC_CNT_RST 8'h03
`define WA_ERR_LIM_RST 6'h03
`define WA_GOOD_CNT_RST 8'h03
`define WA_PAT_LO_RST 32'h0000_017C
`define WA_PAT_HI_RST 8'h00

// ----------------------------------------------------------------------
// status and interrupt bits
// ----------------------------------------------------------------------
`define WA_ST_BND_LSB 8
`define WA_ST_ERR_LSB 16
`define WA_ST_PAT_LSB 24
`define WA_INT_GAIN_BIT 0
`define WA_INT_LOST_BIT 1
`define WA_INT_PAT_BIT 2
`define WA_INT_CERR_BIT 3
`define WA_INT_W 4

`endif

// file: verilog/word_aligner_pkg.sv
// types shared by the word aligner modules
`default_nettype none
package word_aligner_pkg;
  typedef enum logic [1:0] {
    MODE_BITSLIP,
    MODE_MANUAL,
    MODE_SYNC_SM,
    MODE_DET_LAT
  } wa_mode_type;

  typedef enum logic [2:0] {
    ST_LOSS,
    ST_ACQ,
    ST_LOCK,
    ST_ERR,
    ST_SLIP,
    ST_WAIT
  } wa_state_type;
endpackage : word_aligner_pkg
`default_nettype wire

// file: verilog/tx_slip_if.sv
// carrier between the aligner top and its transmit slipper
`default_nettype none
interface tx_slip_if #(
  parameter int DATA_W = 20
);
  logic [DATA_W-1:0] data_in;
  logic [4:0] slip_sel;
  logic slip_en;
  logic [DATA_W-1:0] data_out;

  modport ctrl (output data_in, output slip_sel, output slip_en, input data_out);
  modport slipper (input data_in, input slip_sel, input slip_en, output data_out);
endinterface : tx_slip_if
`default_nettype wire

// file: verilog/tx_bitslip.sv
// transmit bitslip: delays the outgoing word by a selectable bit count
`default_nettype none
module tx_bitslip
  import word_aligner_pkg::*;
#(
  parameter int DATA_W = 20
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  tx_slip_if.slipper tx
);
  logic [DATA_W-1:0] prev_word;
  logic [DATA_W-1:0] out_word;
  logic [4:0] eff_sel;
  logic [2*DATA_W-1:0] pair;
  logic [2*DATA_W-1:0] shifted;

  // selects beyond the word width are clamped to the widest slip
  assign eff_sel = !tx.slip_en ? 5'h00 :
                   (tx.slip_sel >= 5'(DATA_W)) ? 5'(DATA_W - 1) : tx.slip_sel;
  assign pair = {tx.data_in, prev_word};
  assign shifted = pair >> (7'(DATA_W) - 7'(eff_sel));
  assign tx.data_out = out_word;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_word <= '0;
      out_word <= '0;
    end else begin
      prev_word <= tx.data_in;
      out_word <= shifted[DATA_W-1:0];
    end
  end
endmodule : tx_bitslip
`default_nettype wire

// file: verilog/word_aligner.sv
// receive word aligner and transmit bitslip with an APB register file
//
// The APB interface to the registers and the register offsets were decided locally.
`include "word_aligner_regs.svh"
`default_nettype none

module word_aligner
  import word_aligner_pkg::*;
#(
  parameter int DATA_W = 20,
  parameter int PAT_W = 40
) (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic [DATA_W-1:0] RX_PARALLEL_I,
  input wire logic RX_CODE_VALID_I,
  input wire logic RX_CODE_ERR_I,
  input wire logic RX_BITSLIP_I,
  input wire logic RX_MANUAL_REALIGN_REQ_I,
  input wire logic RX_A1A2_SIZE_CTL_I,
  output logic [DATA_W-1:0] RX_ALIGNED_O,
  output logic RX_SYNC_STATUS_O,
  output logic RX_PATTERN_DETECT_O,
  output logic [4:0] RX_SLIP_BOUNDARY_O,
  input wire logic [DATA_W-1:0] TX_PARALLEL_I,
  input wire logic [4:0] TX_SLIP_SEL_I,
  output logic [DATA_W-1:0] TX_PARALLEL_O,
  output logic IRQ_O
);
  localparam int HIST_W = 3 * DATA_W;

  // ----------------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [PAT_W-1:0] window_at(input logic [HIST_W-1:0] h,
                                                 input logic [6:0] sh);
    logic [HIST_W-1:0] t;
    t = h >> sh;
    return t[PAT_W-1:0];
  endfunction : window_at

  function automatic logic [PAT_W-1:0] pat_mask(input logic [2:0] code);
    logic [5:0] len;
    case (code)
      3'h0: len = 6'd7;
      3'h1: len = 6'd8;
      3'h2: len = 6'd10;
      3'h3: len = 6'd16;
      3'h4: len = 6'd20;
      3'h5: len = 6'd32;
      default: len = 6'd40;
    endcase
    return ~({PAT_W{1'b1}} << len);
  endfunction : pat_mask

  function automatic logic [4:0] word_width(input logic [1:0] pma, input logic enc);
    logic [4:0] w;
    case (pma)
      2'h0: w = enc ? 5'd10 : 5'd8;
      2'h1: w = 5'd10;
      2'h2: w = enc ? 5'd20 : 5'd16;
      default: w = 5'd20;
    endcase
    return w;
  endfunction : word_width

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // registers and APB slave
  // ----------------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] pat_lo;
  logic [7:0] pat_hi;
  logic [7:0] sync_need;
  logic [5:0] err_limit;
  logic [7:0] good_need;
  logic [`WA_INT_W-1:0] int_stat;
  logic [`WA_INT_W-1:0] int_mask;
  logic [31:0] rdata;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic addr_ok;
  logic setup;
  logic wr_en;
  logic [`WA_INT_W-1:0] int_evt;

  assign setup = PSEL_I && !PENABLE_I;
  assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
  assign addr_ok = (PADDR_I == `WA_CTRL_OFS) || (PADDR_I == `WA_PAT_LO_OFS) ||
                   (PADDR_I == `WA_PAT_HI_OFS) || (PADDR_I == `WA_SYNC_CFG_OFS) ||
                   (PADDR_I == `WA_STATUS_OFS) || (PADDR_I == `WA_INT_STAT_OFS) ||
                   (PADDR_I == `WA_INT_MASK_OFS);
  assign PREADY_O = PSEL_I && PENABLE_I;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_ok;
  assign PRDATA_O = rdata;
  assign IRQ_O = |(int_stat & int_mask);

  assign next_rdata = (PADDR_I == `WA_CTRL_OFS) ? ctrl :
                      (PADDR_I == `WA_PAT_LO_OFS) ? pat_lo :
                      (PADDR_I == `WA_PAT_HI_OFS) ? {24'h000000, pat_hi} :
                      (PADDR_I == `WA_SYNC_CFG_OFS) ?
                        {8'h00, good_need, 2'h0, err_limit, sync_need} :
                      (PADDR_I == `WA_STATUS_OFS) ? status_word :
                      (PADDR_I == `WA_INT_STAT_OFS) ? {28'h0000000, int_stat} :
                      (PADDR_I == `WA_INT_MASK_OFS) ? {28'h0000000, int_mask} : 32'h0000_0000;

  // read data captured in the setup cycle so the access cycle answers at once
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (setup && !PWRITE_I) begin
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `WA_CTRL_RST;
      pat_lo <= `WA_PAT_LO_RST;
      pat_hi <= `WA_PAT_HI_RST;
      sync_need <= `WA_SYNC_CNT_RST;
      err_limit <= `WA_ERR_LIM_RST;
      good_need <= `WA_GOOD_CNT_RST;
      int_mask <= '0;
    end else if (wr_en) begin
      case (PADDR_I)
        `WA_CTRL_OFS: ctrl <= {16'h0000, PWDATA_I[15:0]};
        `WA_PAT_LO_OFS: pat_lo <= PWDATA_I;
        `WA_PAT_HI_OFS: pat_hi <= PWDATA_I[7:0];
        `WA_SYNC_CFG_OFS: begin
          sync_need <= PWDATA_I[`WA_CFG_SYNC_LSB +: 8];
          err_limit <= PWDATA_I[`WA_CFG_ERR_LSB +: 6];
          good_need <= PWDATA_I[`WA_CFG_GOOD_LSB +: 8];
        end
        `WA_INT_MASK_OFS: int_mask <= PWDATA_I[`WA_INT_W-1:0];
        default: ;
      endcase
    end
  end

  // events win over a write-one clear in the same cycle
  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      int_stat <= '0;
    end else if (wr_en && PADDR_I == `WA_INT_STAT_OFS) begin
      int_stat <= (int_stat & ~PWDATA_I[`WA_INT_W-1:0]) | int_evt;
    end else begin
      int_stat <= int_stat | int_evt;
    end
  end

  // ----------------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------------
  wa_mode_type mode;
  logic [2:0] plen_code;
  logic [4:0] wwidth;
  logic fast_sync;
  logic [PAT_W-1:0] pattern;
  logic [PAT_W-1:0] plen_mask;

  assign mode = wa_mode_type'(ctrl[`WA_CTRL_MODE_LSB +: 2]);
  assign wwidth = word_width(ctrl[`WA_CTRL_PMAW_LSB +: 2], ctrl[`WA_CTRL_ENC_BIT]);
  // fabric picks 16 or 32 bit A1A2 framing when its port is enabled
  assign plen_code = !ctrl[`WA_CTRL_A1A2_BIT] ? ctrl[`WA_CTRL_PLEN_LSB +: 3] :
                     RX_A1A2_SIZE_CTL_I ? 3'h5 : 3'h3;
  assign plen_mask = pat_mask(plen_code);
  assign pattern = {pat_hi, pat_lo};
  assign fast_sync = ctrl[`WA_CTRL_FAST_BIT] && ctrl[`WA_CTRL_CPRI_BIT];

  // ----------------------------------------------------------------------
  // bit history and pattern search
  // ----------------------------------------------------------------------
  // newest word enters at the top; narrow widths leave a shorter search span
  logic [HIST_W-1:0] hist;
  logic [HIST_W-1:0] next_hist;
  logic [HIST_W-1:0] in_word;
  logic [6:0] base;
  logic [DATA_W-1:0] match_vec;
  logic any_match;
  logic [4:0] first_off;
  logic [4:0] boundary;
  logic bnd_match;

  assign in_word = {{(HIST_W-DATA_W){1'b0}}, RX_PARALLEL_I & ~({DATA_W{1'b1}} << wwidth)};
  assign next_hist = (hist >> wwidth) | (in_word << (7'(HIST_W) - 7'(wwidth)));
  assign base = 7'(HIST_W) - 7'(3 * wwidth);

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      hist <= '0;
    end else begin
      hist <= next_hist;
    end
  end

  genvar g;
  generate
    for (g = 0; g < DATA_W; g++) begin : g_cmp
      logic [PAT_W-1:0] win;
      assign win = window_at(hist, base + 7'(g));
      assign match_vec[g] = (5'(g) < wwidth) && (((win ^ pattern) & plen_mask) == '0);
    end
  endgenerate

  always_comb begin
    first_off = 5'h00;
    for (int i = DATA_W - 1; i >= 0; i--) begin
      if (match_vec[i]) begin
        first_off = 5'(i);
      end
    end
  end

  assign any_match = |match_vec;
  assign bnd_match = match_vec[boundary];

  // ----------------------------------------------------------------------
  // alignment state machine
  // ----------------------------------------------------------------------
  wa_state_type state;
  wa_state_type next_state;
  wa_mode_type mode_q;
  logic [4:0] next_boundary;
  logic [7:0] pat_cnt;
  logic [7:0] next_pat_cnt;
  logic [5:0] err_cnt;
  logic [5:0] next_err_cnt;
  logic [7:0] good_cnt;
  logic [7:0] next_good_cnt;
  logic sync;
  logic next_sync;
  logic slip_q;
  logic realign_q;
  logic slip_edge;
  logic realign_edge;

  assign slip_edge = RX_BITSLIP_I && !slip_q && ctrl[`WA_CTRL_RXSLIP_BIT];
  assign realign_edge = RX_MANUAL_REALIGN_REQ_I && !realign_q && ctrl[`WA_CTRL_REALIGN_BIT];

  always_comb begin
    next_state = state;
    next_boundary = boundary;
    next_pat_cnt = pat_cnt;
    next_err_cnt = err_cnt;
    next_good_cnt = good_cnt;
    next_sync = sync;
    if (mode != mode_q) begin
      next_state = ST_LOSS;
      next_sync = 1'b0;
      next_pat_cnt = 8'h00;
      next_err_cnt = 6'h00;
    end else begin
      case (mode)
        MODE_BITSLIP: begin
          next_sync = 1'b0;
          if (slip_edge) begin
            next_boundary = (boundary + 5'h01 >= wwidth) ? 5'h00 : boundary + 5'h01;
          end
        end
        MODE_MANUAL: begin
          if (realign_edge) begin
            next_state = ST_WAIT;
            next_sync = 1'b0;
          end else if (state == ST_WAIT && any_match) begin
            next_boundary = first_off;
            next_state = ST_LOCK;
            next_sync = 1'b1;
          end
        end
        MODE_SYNC_SM: begin
          case (state)
            ST_LOSS: begin
              if (any_match) begin
                next_boundary = first_off;
                next_pat_cnt = 8'h01;
                next_state = (sync_need <= 8'h01) ? ST_LOCK : ST_ACQ;
              end
            end
            ST_ACQ: begin
              if (RX_CODE_ERR_I) begin
                next_state = ST_LOSS;
              end else if (bnd_match) begin
                next_pat_cnt = pat_cnt + 8'h01;
                if (pat_cnt + 8'h01 >= sync_need) begin
                  next_state = ST_LOCK;
                end
              end
            end
            ST_LOCK: begin
              if (RX_CODE_ERR_I) begin
                next_err_cnt = 6'h01;
                next_good_cnt = 8'h00;
                next_state = (err_limit <= 6'h01) ? ST_LOSS : ST_ERR;
              end
            end
            ST_ERR: begin
              if (RX_CODE_ERR_I) begin
                next_err_cnt = err_cnt + 6'h01;
                next_good_cnt = 8'h00;
                if (err_cnt + 6'h01 >= err_limit) begin
                  next_state = ST_LOSS;
                end
              end else if (RX_CODE_VALID_I) begin
                if (good_cnt + 8'h01 >= good_need) begin
                  next_good_cnt = 8'h00;
                  next_err_cnt = err_cnt - 6'h01;
                  if (err_cnt == 6'h01) begin
                    next_state = ST_LOCK;
                  end
                end else begin
                  next_good_cnt = good_cnt + 8'h01;
                end
              end
            end
            default: next_state = ST_LOSS;
          endcase
          next_sync = (next_state == ST_LOCK) || (next_state == ST_ERR);
          if (next_state == ST_LOSS) begin
            next_err_cnt = 6'h00;
            next_pat_cnt = 8'h00;
          end
        end
        default: begin
          // fixed latency: search, slip one cycle, then report at once with fast sync or after the next match
          case (state)
            ST_LOSS: begin
              next_sync = 1'b0;
              if (any_match) begin
                next_boundary = first_off;
                next_state = ST_SLIP;
              end
            end
            ST_SLIP: begin
              if (fast_sync) begin
                next_state = ST_LOCK;
                next_sync = 1'b1;
              end else begin
                next_state = ST_WAIT;
              end
            end
            ST_WAIT: begin
              if (bnd_match) begin
                next_state = ST_LOCK;
                next_sync = 1'b1;
              end
            end
            ST_LOCK: ;
            default: next_state = ST_LOSS;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_LOSS;
      mode_q <= MODE_BITSLIP;
      boundary <= 5'h00;
      pat_cnt <= 8'h00;
      err_cnt <= 6'h00;
      good_cnt <= 8'h00;
      sync <= 1'b0;
      slip_q <= 1'b0;
      realign_q <= 1'b0;
    end else begin
      state <= next_state;
      mode_q <= mode;
      boundary <= next_boundary;
      pat_cnt <= next_pat_cnt;
      err_cnt <= next_err_cnt;
      good_cnt <= next_good_cnt;
      sync <= next_sync;
      slip_q <= RX_BITSLIP_I;
      realign_q <= RX_MANUAL_REALIGN_REQ_I;
    end
  end

  // ----------------------------------------------------------------------
  // receive outputs
  // ----------------------------------------------------------------------
  logic [PAT_W-1:0] aligned_win;
  logic [DATA_W-1:0] aligned;
  logic pat_det;

  assign aligned_win = window_at(hist, base + 7'(boundary));

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aligned <= '0;
      pat_det <= 1'b0;
    end else begin
      aligned <= aligned_win[DATA_W-1:0] & ~({DATA_W{1'b1}} << wwidth);
      pat_det <= bnd_match && (mode != MODE_BITSLIP);
    end
  end

  assign RX_ALIGNED_O = aligned;
  assign RX_SYNC_STATUS_O = sync;
  assign RX_PATTERN_DETECT_O = pat_det;
  assign RX_SLIP_BOUNDARY_O = ctrl[`WA_CTRL_RXBND_BIT] ? boundary : 5'h00;

  assign status_word = {pat_cnt, 2'h0, err_cnt, 3'h0, boundary, 6'h00, pat_det, sync};
  assign int_evt = {RX_CODE_ERR_I && sync, pat_det, sync && !next_sync, !sync && next_sync};

  // ----------------------------------------------------------------------
  // transmit bitslip
  // ----------------------------------------------------------------------
  tx_slip_if #(.DATA_W(DATA_W)) tx_bus ();

  assign tx_bus.data_in = TX_PARALLEL_I;
  assign tx_bus.slip_en = ctrl[`WA_CTRL_TXSLIP_BIT];
  assign tx_bus.slip_sel = ctrl[`WA_CTRL_TXSEL_BIT] ? TX_SLIP_SEL_I : 5'h00;
  assign TX_PARALLEL_O = tx_bus.data_out;

  tx_bitslip #(.DATA_W(DATA_W)) u_tx_slip (
    .clk_i(CORE_CLK_I),
    .rst_n_i(rst_n),
    .tx(tx_bus.slipper)
  );
endmodule : word_aligner
`default_nettype wire

// file: verification/word_aligner_sva.sv
// port-level assertions for the word aligner top
`default_nettype none
module word_aligner_sva #(
  parameter int DATA_W = 20
) (
  input wire logic CORE_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic RX_CODE_ERR_I,
  input wire logic RX_MANUAL_REALIGN_REQ_I,
  input wire logic RX_SYNC_STATUS_O,
  input wire logic [4:0] RX_SLIP_BOUNDARY_O,
  input wire logic [DATA_W-1:0] TX_PARALLEL_I,
  input wire logic [4:0] TX_SLIP_SEL_I,
  input wire logic [DATA_W-1:0] TX_PARALLEL_O
);
  timeunit 1ns;
  timeprecision 1ps;
  wire acc = PSEL_I && PENABLE_I;
  wire rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire wr_acc = acc && PWRITE_I;
  wire rq = RX_MANUAL_REALIGN_REQ_I;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  a_ready_access: assert property (acc |-> PREADY_O)
    else $error("ready missing in access");
  a_ready_idle: assert property (!acc |-> !PREADY_O)
    else $error("ready outside access");
  a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
    else $error("slave error without ready");
  a_err_read_zero: assert property (PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0000_0000)
    else $error("refused read not zero");
  a_rdata_hold: assert property (!rd_setup |=> $stable(PRDATA_O))
    else $error("read data moved");
  a_bnd_range: assert property (RX_SLIP_BOUNDARY_O < 5'h14)
    else $error("boundary out of range");
  a_tx_no_slip: assert property ($past(TX_SLIP_SEL_I) == 5'h00 |->
    TX_PARALLEL_O == $past(TX_PARALLEL_I)) else $error("tx word slipped");
  a_sync_drop_cause: assert property ($fell(RX_SYNC_STATUS_O) |->
    $past(RX_CODE_ERR_I) || $past(RX_CODE_ERR_I, 2) || $past(wr_acc) || $past(wr_acc, 2)
    || $past(rq) || $past(rq, 2)) else $error("sync lost without cause");
endmodule : word_aligner_sva

bind word_aligner word_aligner_sva #(.DATA_W(DATA_W)) word_aligner_sva_inst (
  .CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .RX_CODE_ERR_I(RX_CODE_ERR_I), .RX_MANUAL_REALIGN_REQ_I(RX_MANUAL_REALIGN_REQ_I),
  .RX_SYNC_STATUS_O(RX_SYNC_STATUS_O), .RX_SLIP_BOUNDARY_O(RX_SLIP_BOUNDARY_O),
  .TX_PARALLEL_I(TX_PARALLEL_I), .TX_SLIP_SEL_I(TX_SLIP_SEL_I), .TX_PARALLEL_O(TX_PARALLEL_O));
`default_nettype wire

// file: verification/fabric_rx_model.sv
// fabric-side source of receive words and decoder code strobes
`default_nettype none
module fabric_rx_model (
  input wire logic clk_i,
  input wire logic pat_i,
  input wire logic err_i,
  input wire logic good_i,
  output logic [19:0] data_o,
  output logic valid_o,
  output logic err_o,
  output logic a1a2_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign a1a2_o = 1'b0;
  initial begin
    data_o = 20'h00000;
    valid_o = 1'b0;
    err_o = 1'b0;
  end
  // all-ones word between zero fillers fits at one boundary only
  always @(posedge clk_i) begin
    data_o <= pat_i ? 20'hFFFFF : 20'h00000;
    valid_o <= good_i;
    err_o <= err_i;
  end
endmodule : fabric_rx_model
`default_nettype wire

// file: verification/word_aligner_test.sv
// self-checking bench of the word aligner
`include "word_aligner_regs.svh"
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end
module word_aligner_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000, prd, q;
  logic rdy, slv, e, pat = 1'b0, cerr = 1'b0, good = 1'b0, valid, err, a1a2, sync, pdet, irq;
  logic [19:0] rxd, rxa, txo, txi = 20'h00000;
  logic [4:0] bnd, tsel = 5'h00;
  logic bs = 1'b0, rq = 1'b0;
  logic [39:0] cat = {20'hABCDE, 20'h12345};
  int fails = 0, num_checks = 0;
  always #10 clk = ~clk;
  fabric_rx_model fabric_rx_model_inst (.clk_i(clk), .pat_i(pat), .err_i(cerr), .good_i(good),
    .data_o(rxd), .valid_o(valid), .err_o(err), .a1a2_o(a1a2));
  word_aligner word_aligner_inst (.CORE_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(rdy), .PSLVERR_O(slv), .RX_PARALLEL_I(rxd), .RX_CODE_VALID_I(valid),
    .RX_CODE_ERR_I(err), .RX_BITSLIP_I(bs), .RX_MANUAL_REALIGN_REQ_I(rq),
    .RX_A1A2_SIZE_CTL_I(a1a2), .RX_ALIGNED_O(rxa), .RX_SYNC_STATUS_O(sync),
    .RX_PATTERN_DETECT_O(pdet), .RX_SLIP_BOUNDARY_O(bnd), .TX_PARALLEL_I(txi),
    .TX_SLIP_SEL_I(tsel), .TX_PARALLEL_O(txo), .IRQ_O(irq));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task automatic hang;
    fails++;
    complete_run();
  endtask : hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n >= 20) hang();
    q = prd;
    e = slv;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  // kind 0 pattern, 1 code error, 2 good code; tail lets the pipeline settle
  task automatic pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      pat <= (k == 0);
      cerr <= (k == 1);
      good <= (k == 2);
      @(posedge clk);
      pat <= 1'b0;
      cerr <= 1'b0;
      good <= 1'b0;
    end
    repeat (8) @(posedge clk);
  endtask : pulse
  task automatic reg_reset;
    logic [11:0] ad [5] = '{`WA_CTRL_OFS, `WA_PAT_LO_OFS, `WA_PAT_HI_OFS, `WA_SYNC_CFG_OFS,
      `WA_INT_MASK_OFS};
    logic [31:0] rv [5] = '{32'h0000_0078, 32'h0000_017C, 32'h0, 32'h0003_0303, 32'h0};
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ad[i], 32'h0);
      `CHK("reset value", rv[i], q)
    end
    apb(1'b0, 12'h01C, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0000_0000, q)
  endtask : reg_reset
  task automatic sync_sm;
    apb(1'b1, `WA_PAT_LO_OFS, 32'h000F_FFFF);
    apb(1'b1, `WA_INT_MASK_OFS, 32'h0000_0001);
    apb(1'b1, `WA_CTRL_OFS, 32'h0000_0072);
    pulse(0, 2);
    `CHK("sync early", 1'b0, sync)
    pulse(0, 1);
    `CHK("sync", 1'b1, sync)
    `CHK("irq gain", 1'b1, irq)
    apb(1'b1, `WA_INT_STAT_OFS, 32'h0000_0001);
    @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
  endtask : sync_sm
  task automatic errors;
    pulse(1, 2);
    apb(1'b0, `WA_STATUS_OFS, 32'h0);
    `CHK("err count", 6'h02, q[21:16])
    `CHK("sync held", 1'b1, q[0])
    pulse(2, 3);
    apb(1'b0, `WA_STATUS_OFS, 32'h0);
    `CHK("err count dec", 6'h01, q[21:16])
    pulse(2, 3);
    apb(1'b0, `WA_STATUS_OFS, 32'h0);
    `CHK("err count zero", 6'h00, q[21:16])
    `CHK("relocked", 1'b1, q[0])
    pulse(1, 3);
    `CHK("sync lost", 1'b0, sync)
    apb(1'b0, `WA_INT_STAT_OFS, 32'h0);
    `CHK("int status", 32'h0000_000E, q)
    `CHK("irq masked", 1'b0, irq)
  endtask : errors
  task automatic tx_slip(input logic [31:0] c, input logic [19:0] x);
    apb(1'b1, `WA_CTRL_OFS, c);
    tsel <= 5'h03;
    txi <= 20'h12345;
    @(posedge clk);
    txi <= 20'hABCDE;
    @(posedge clk);
    // slipped word stands one cycle; judged between edges
    @(negedge clk);
    `CHK("tx word", x, txo)
    @(posedge clk);
    tsel <= 5'h00;
  endtask : tx_slip
  // detect stands one cycle, so it is looked for at falling edges
  task automatic see_pdet;
    int n;
    n = 0;
    @(posedge clk);
    pat <= 1'b1;
    @(posedge clk);
    pat <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (pdet !== 1'b1 && n < 20);
    if (n >= 20) hang();
    `CHK("aligned word", 20'hFFFF0, rxa)
    repeat (8) @(posedge clk);
  endtask : see_pdet
  // pattern 0xFFF0 over 16 bits only fits at offset 16 of the model's words
  task automatic manual;
    apb(1'b1, `WA_PAT_LO_OFS, 32'h0000_FFF0);
    apb(1'b1, `WA_CTRL_OFS, 32'h0000_506D);
    @(posedge clk);
    rq <= 1'b1;
    @(posedge clk);
    rq <= 1'b0;
    pulse(0, 1);
    `CHK("manual sync", 1'b1, sync)
    `CHK("manual boundary", 5'h10, bnd)
    see_pdet();
  endtask : manual
  task automatic det_lat;
    apb(1'b1, `WA_CTRL_OFS, 32'h0000_416F);
    pulse(0, 1);
    `CHK("slow sync early", 1'b0, sync)
    pulse(0, 1);
    `CHK("slow sync", 1'b1, sync)
    apb(1'b1, `WA_CTRL_OFS, 32'h0000_C06C);
    repeat (2) begin
      @(posedge clk);
      bs <= 1'b1;
      @(posedge clk);
      bs <= 1'b0;
    end
    @(posedge clk);
    `CHK("slip boundary", 5'h12, bnd)
    `CHK("slip no sync", 1'b0, sync)
    apb(1'b1, `WA_CTRL_OFS, 32'h0000_436F);
    pulse(0, 1);
    `CHK("fast sync", 1'b1, sync)
  endtask : det_lat
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    reg_reset();
    sync_sm();
    errors();
    tx_slip(32'h0000_0C72, cat[36:17]);
    tx_slip(32'h0000_0472, 20'hABCDE);
    manual();
    det_lat();
    complete_run();
  end
endmodule : word_aligner_test
`default_nettype wire
